/* File: rtl/asf_defines.svh */
`ifndef ASF_DEFINES_SVH
`define ASF_DEFINES_SVH

// Register address of the status byte on the plain port
`define ASF_ADDR_STATUS 8'h00
// Field positions
`define ASF_BIT_NEG 4
`define ASF_BIT_OVF 3
`define ASF_BIT_ZERO 2
`define ASF_BIT_NCARRY 1
`define ASF_BIT_CARRY 0
`define ASF_BIT_MSB 7
`define ASF_BIT_NIBBLE 4
`define ASF_NIB_MSB 3
`define ASF_BIT_COUT 8
`define ASF_FLAG_MSB 4
`define ASF_PAD_ZERO 3'h0
// Implemented flag mask
`define ASF_FLAG_MASK 8'h1F
`define ASF_ZERO_BYTE 8'h00
`define ASF_ZERO_FLAGS 5'h00

`endif

/* File: rtl/asf_pkg.sv */
package asf_pkg;

	// Operation classes the execution logic reports
	typedef enum logic [3:0] {
		ASF_OP_NONE = 4'h1,
		ASF_OP_ADD = 4'h2,
		ASF_OP_SUB = 4'h4,
		ASF_OP_LOGIC = 4'h8
	} asf_op_t;

	// One ALU request: operands, class and which flags it touches
	typedef struct packed {
		asf_op_t op;
		logic [7:0] opa;
		logic [7:0] opb;
		logic carry_in;
		logic use_carry;
		logic [4:0] flag_en;
		logic dest_status;
	} asf_alu_req_t;

	// Result back to the execution logic
	typedef struct packed {
		logic [7:0] result;
		logic [4:0] flags;
	} asf_alu_rsp_t;

endpackage

/* File: rtl/asf_status.sv */
// Notes on behaviour
// RULE1 - Flag-updating op on status blocks flag write
// RULE2 - Clear aimed at status sets zero only
// RULE3 - Status usable as any operand
// RULE4 - Bits seven to five read zero
// RULE5 - Negative flag equals result MSB
// RULE6 - Overflow set when signed sign flips
// RULE7 - Zero flag tracks zero result
// RULE8 - Nibble carry from bit three out
// RULE9 - Carry from MSB out on add/sub
// RULE10 - Subtract adds complement; carries mean no-borrow
// RULE11 - Software prefers non-flag ops on status
// RULE12 - Flags power up unknown, hold until changed
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "asf_defines.svh"

// One stored flag bit; five copies make the status byte
module asf_flag_cell (
	// Clock
	input wire logic clk,
	// Software write
	input wire logic wr_hit,
	input wire logic wr_bit,
	// Instruction side
	input wire logic alu_valid,
	input wire logic dest_status,
	input wire logic move_op,
	input wire logic move_bit,
	input wire logic upd_en,
	input wire logic calc_bit,
	// Stored value
	output logic flag
);

	logic owned;
	logic instr_bit;
	logic next_flag;

	// What the instruction leaves in this bit when it claims it
	always_comb begin
		owned = 1'h0;
		instr_bit = flag;
		if (alu_valid) begin
			if (upd_en) begin
				owned = 1'h1;
				instr_bit = calc_bit; // RULE1 RULE2
			end else if (dest_status) begin
				owned = 1'h1;
				if (move_op) begin
					instr_bit = move_bit; // RULE3
				end else begin
					instr_bit = flag; // RULE1
				end
			end
		end
	end

	// Instruction beats a software write to the same bit
	always_comb begin
		if (owned) begin
			next_flag = instr_bit;
		end else if (wr_hit) begin
			next_flag = wr_bit; // RULE3
		end else begin
			next_flag = flag;
		end
	end

	// No reset: the bit powers up unknown and holds until changed
	always_ff @(posedge clk) begin
		flag <= next_flag; // RULE12
	end
endmodule

module asf_status
	import asf_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// ALU side
	input wire logic ALU_VALID,
	input wire asf_alu_req_t ALU_REQ,
	output asf_alu_rsp_t ALU_RSP,
	// Status byte for instructions sourcing it
	output logic [7:0] STATUS_VALUE
);

	// Stored flags and read path
	logic [`ASF_FLAG_MSB:0] flags;
	logic [7:0] rdata;
	logic [7:0] rd_value;
	// Operation decode
	logic is_add;
	logic is_sub;
	logic is_arith;
	logic is_move;
	// Adder operands, widened on purpose
	logic [7:0] opb_eff;
	logic cin;
	logic [4:0] nib_a;
	logic [4:0] nib_b;
	logic [4:0] nib_c;
	logic [8:0] byte_a;
	logic [8:0] byte_b;
	logic [8:0] byte_c;
	logic [4:0] low_sum;
	logic [8:0] full_sum;
	logic [7:0] res;
	// Candidate flags
	logic calc_neg;
	logic calc_ovf;
	logic calc_zero;
	logic calc_ncarry;
	logic calc_carry;
	logic [`ASF_FLAG_MSB:0] calc;
	// Per-bit sources for the flag cells
	logic [`ASF_FLAG_MSB:0] wr_bits;
	logic [`ASF_FLAG_MSB:0] move_bits;
	logic [`ASF_FLAG_MSB:0] upd_bits;
	// Register port decode
	logic status_hit;
	logic status_rd;

	// One-hot class code, so each compare is a single bit in practice
	assign is_add = (ALU_REQ.op == ASF_OP_ADD);
	assign is_sub = (ALU_REQ.op == ASF_OP_SUB);
	assign is_arith = is_add || is_sub;
	assign is_move = (ALU_REQ.op == ASF_OP_NONE);

	// Subtract is add of the complement
	always_comb begin
		if (is_sub) begin
			opb_eff = ~ALU_REQ.opb; // RULE10
		end else begin
			opb_eff = ALU_REQ.opb;
		end
	end

	// Chained ops take the caller's carry instead of the implicit one
	always_comb begin
		if (ALU_REQ.use_carry) begin
			cin = ALU_REQ.carry_in;
		end else if (is_sub) begin
			cin = 1'h1; // RULE10
		end else begin
			cin = 1'h0;
		end
	end

	// Explicit widening keeps every adder term the width of its sum
	assign nib_a = {1'h0, ALU_REQ.opa[`ASF_NIB_MSB:0]};
	assign nib_b = {1'h0, opb_eff[`ASF_NIB_MSB:0]};
	assign nib_c = {4'h0, cin};
	assign byte_a = {1'h0, ALU_REQ.opa};
	assign byte_b = {1'h0, opb_eff};
	assign byte_c = {8'h00, cin};

	// Low nibble summed apart to expose its carry
	assign low_sum = nib_a + nib_b + nib_c;
	assign full_sum = byte_a + byte_b + byte_c;

	// Logic results arrive precomputed; moves pass the operand through
	always_comb begin
		if (is_arith) begin
			res = full_sum[`ASF_BIT_MSB:0];
		end else begin
			res = ALU_REQ.opa;
		end
	end

	assign calc_neg = res[`ASF_BIT_MSB]; // RULE5
	assign calc_zero = (res == `ASF_ZERO_BYTE); // RULE7

	// Signs alike going in, different coming out
	always_comb begin
		if (is_arith) begin
			calc_ovf = (ALU_REQ.opa[`ASF_BIT_MSB] == opb_eff[`ASF_BIT_MSB])
				&& (res[`ASF_BIT_MSB] != ALU_REQ.opa[`ASF_BIT_MSB]); // RULE6
		end else begin
			calc_ovf = 1'h0; // RULE6
		end
	end

	// Nibble carry only means something after add or subtract
	always_comb begin
		if (is_arith) begin
			calc_ncarry = low_sum[`ASF_BIT_NIBBLE]; // RULE8
		end else begin
			calc_ncarry = flags[`ASF_BIT_NCARRY];
		end
	end

	// Same for the byte carry; other ops keep the stored value
	always_comb begin
		if (is_arith) begin
			calc_carry = full_sum[`ASF_BIT_COUT]; // RULE9
		end else begin
			calc_carry = flags[`ASF_BIT_CARRY];
		end
	end

	// Pack in status bit order
	always_comb begin
		calc = `ASF_ZERO_FLAGS;
		calc[`ASF_BIT_NEG] = calc_neg;
		calc[`ASF_BIT_OVF] = calc_ovf;
		calc[`ASF_BIT_ZERO] = calc_zero;
		calc[`ASF_BIT_NCARRY] = calc_ncarry;
		calc[`ASF_BIT_CARRY] = calc_carry;
	end

	// Only the status byte lives on this port; other writes vanish
	always_comb begin
		status_hit = 1'h0;
		if (REG_ADDR == `ASF_ADDR_STATUS) begin
			status_hit = REG_WR;
		end
	end

	// Reads of other addresses answer zero
	always_comb begin
		status_rd = 1'h0;
		if (REG_ADDR == `ASF_ADDR_STATUS) begin
			status_rd = REG_RD;
		end
	end

	assign wr_bits = REG_WDATA[`ASF_FLAG_MSB:0];
	assign move_bits = res[`ASF_FLAG_MSB:0];
	assign upd_bits = ALU_REQ.flag_en;

	// Five flag cells share the same write and claim logic

	// Negative flag
	asf_flag_cell neg_cell_i (
		.clk(MCLK),
		.wr_hit(status_hit),
		.wr_bit(wr_bits[`ASF_BIT_NEG]),
		.alu_valid(ALU_VALID),
		.dest_status(ALU_REQ.dest_status),
		.move_op(is_move),
		.move_bit(move_bits[`ASF_BIT_NEG]),
		.upd_en(upd_bits[`ASF_BIT_NEG]),
		.calc_bit(calc[`ASF_BIT_NEG]),
		.flag(flags[`ASF_BIT_NEG])
	);

	// Signed overflow flag
	asf_flag_cell ovf_cell_i (
		.clk(MCLK),
		.wr_hit(status_hit),
		.wr_bit(wr_bits[`ASF_BIT_OVF]),
		.alu_valid(ALU_VALID),
		.dest_status(ALU_REQ.dest_status),
		.move_op(is_move),
		.move_bit(move_bits[`ASF_BIT_OVF]),
		.upd_en(upd_bits[`ASF_BIT_OVF]),
		.calc_bit(calc[`ASF_BIT_OVF]),
		.flag(flags[`ASF_BIT_OVF])
	);

	// Zero flag
	asf_flag_cell zero_cell_i (
		.clk(MCLK),
		.wr_hit(status_hit),
		.wr_bit(wr_bits[`ASF_BIT_ZERO]),
		.alu_valid(ALU_VALID),
		.dest_status(ALU_REQ.dest_status),
		.move_op(is_move),
		.move_bit(move_bits[`ASF_BIT_ZERO]),
		.upd_en(upd_bits[`ASF_BIT_ZERO]),
		.calc_bit(calc[`ASF_BIT_ZERO]),
		.flag(flags[`ASF_BIT_ZERO])
	);

	// Nibble carry flag
	asf_flag_cell ncarry_cell_i (
		.clk(MCLK),
		.wr_hit(status_hit),
		.wr_bit(wr_bits[`ASF_BIT_NCARRY]),
		.alu_valid(ALU_VALID),
		.dest_status(ALU_REQ.dest_status),
		.move_op(is_move),
		.move_bit(move_bits[`ASF_BIT_NCARRY]),
		.upd_en(upd_bits[`ASF_BIT_NCARRY]),
		.calc_bit(calc[`ASF_BIT_NCARRY]),
		.flag(flags[`ASF_BIT_NCARRY])
	);

	// Carry flag
	asf_flag_cell carry_cell_i (
		.clk(MCLK),
		.wr_hit(status_hit),
		.wr_bit(wr_bits[`ASF_BIT_CARRY]),
		.alu_valid(ALU_VALID),
		.dest_status(ALU_REQ.dest_status),
		.move_op(is_move),
		.move_bit(move_bits[`ASF_BIT_CARRY]),
		.upd_en(upd_bits[`ASF_BIT_CARRY]),
		.calc_bit(calc[`ASF_BIT_CARRY]),
		.flag(flags[`ASF_BIT_CARRY])
	);

	// Unimplemented top bits are tied low
	assign rd_value = {`ASF_PAD_ZERO, flags}; // RULE4

	// Zero when idle, so several slaves can share one read bus
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			rdata <= `ASF_ZERO_BYTE;
		end else if (status_rd) begin
			rdata <= rd_value; // RULE4
		end else begin
			rdata <= `ASF_ZERO_BYTE;
		end
	end

	assign REG_RDATA = rdata;
	assign STATUS_VALUE = rd_value; // RULE4

	// Candidate flags go back unmasked; the cells apply the enables
	always_comb begin
		ALU_RSP.result = res;
		ALU_RSP.flags = calc;
	end

endmodule

/* File: verification/asf_exec_model.sv */
module asf_exec_model
	import asf_pkg::*;
(
	// Requests from the bench, replayed to the flag block
	input wire logic clk,
	input wire logic go,
	input wire asf_alu_req_t cmd,
	output logic valid = 1'b0,
	output asf_alu_req_t req = '0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered so requests change just after an edge
	always @(posedge clk) {valid, req} <= {go, cmd};
endmodule

/* File: verification/asf_status_monitor.sv */
module asf_status_monitor
	import asf_pkg::*;
(
	// Watched ports
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic ALU_VALID,
	input wire asf_alu_req_t ALU_REQ,
	input wire asf_alu_rsp_t ALU_RSP,
	input wire logic [7:0] STATUS_VALUE
);
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);
	wire [8:0] cr = {ALU_RSP.flags[0], ALU_RSP.result};
	wire [7:0] x = ALU_REQ.opa;
	wire [7:0] y = ALU_REQ.opb;
	wire ar = ALU_VALID && ALU_REQ.op != ASF_OP_NONE;
	wire ad = ALU_VALID && ALU_REQ.op == ASF_OP_ADD && !ALU_REQ.use_carry;
	wire sb = ALU_VALID && ALU_REQ.op == ASF_OP_SUB && !ALU_REQ.use_carry;
	chk_top_zero: assert property (STATUS_VALUE[7:5] == 3'h0) else $error("top bits");
	chk_read_back: assert property (
		REG_RD && !REG_ADDR |=> REG_RDATA == $past(STATUS_VALUE)) else $error("read back");
	chk_neg_msb: assert property (ar |-> ALU_RSP.flags[4] == cr[7]) else $error("n flag");
	chk_zero_res: assert property (
		ar |-> ALU_RSP.flags[2] == (cr[7:0] == 8'h00)) else $error("z flag");
	chk_add_cry: assert property (ad |-> cr == x + y) else $error("add carry");
	chk_nib_cry: assert property (
		ad |-> ALU_RSP.flags[1] == (x[3:0] + y[3:0] + 5'h00 > 5'h0F)) else $error("dc flag");
	chk_sub_brw: assert property (
		sb |-> cr == x + {1'b0, ~y} + 9'h001) else $error("borrow");
	chk_flag_set: assert property (
		ALU_VALID && ALU_REQ.dest_status && &ALU_REQ.flag_en |=>
		STATUS_VALUE[4:0] == $past(ALU_RSP.flags)) else $error("flag write");
endmodule
bind asf_status asf_status_monitor asf_status_monitor_i (.*);

/* File: verification/test_alu_status_flags.sv */
module test_alu_status_flags;
	import asf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, go = 0, wr = 0, rd = 0, valid;
	logic [7:0] ad = 0, wd = 0, rdat, sv;
	logic [4:0] mf;
	asf_alu_req_t cmd = '0, req;
	asf_alu_rsp_t rsp;
	int fails = 0, tests_run = 0, cyc = 0;
	asf_exec_model asf_exec_model_i (.clk(clk), .go(go), .cmd(cmd), .valid(valid), .req(req));
	asf_status asf_status_i (.MCLK(clk), .SYS_RST(rst), .REG_ADDR(ad), .REG_WDATA(wd),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .ALU_VALID(valid), .ALU_REQ(req),
		.ALU_RSP(rsp), .STATUS_VALUE(sv));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) if (++cyc == 3000) begin
		fails++;
		conclude();
	end
	task automatic chk(input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("FAIL %0t %h %h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("compared %0d mismatched %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, d);
		{ad, wd, wr} <= {a, d, 1'b1};
		@(posedge clk) wr <= 0;
		if (a == 8'h00) mf = d[4:0];
	endtask
	// Read data stands one cycle, so it is taken at that edge before it clears
	task automatic rreg(input logic [7:0] a, e);
		{ad, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 0;
		@(posedge clk) chk(rdat, e);
	endtask
	task automatic alu(input asf_op_t op, input logic [7:0] x, y, input logic [4:0] en,
		input logic uc = 1'b0);
		int v, s, n, c, a;
		a = op == ASF_OP_ADD || op == ASF_OP_SUB;
		c = uc ? mf[0] : op == ASF_OP_SUB;
		v = op == ASF_OP_SUB ? 255 - y : y;
		s = a ? x + v + c : x;
		n = x % 16 + v % 16 + c;
		{cmd, go} <= {op, x, y, mf[0], uc, en, 1'b1, 1'b1};
		if (op == ASF_OP_NONE) mf = x[4:0];
		mf = (mf & ~en) | (en & {s[7], ((x ^ s) & (v ^ s) & 128) != 0 && a,
			s % 256 == 0, n > 15, s > 255});
		@(posedge clk) go <= 0;
		@(posedge clk) chk(rsp.result, 8'(s));
		@(posedge clk) chk(sv, {3'h0, mf});
	endtask
	initial begin
		void'($urandom(67));
		repeat (16) @(posedge clk);
		rst <= 0;
		wreg(8'h00, 8'hFF);
		rreg(8'h00, 8'h1F);
		wreg(8'h01, 8'h00);
		rreg(8'h01, 8'h00);
		alu(ASF_OP_ADD, 8'h7F, 8'h01, 5'h1F);
		alu(ASF_OP_LOGIC, 8'h00, 8'h00, 5'h04);
		alu(ASF_OP_NONE, 8'h35, 8'h00, 5'h00);
		repeat (60) alu($urandom % 2 ? ASF_OP_ADD : ASF_OP_SUB, 8'($urandom), 8'($urandom),
			5'h1F, 1'($urandom));
		rreg(8'h00, {3'h0, mf});
		$display("all tests done");
		conclude();
	end
endmodule
